// file: logic/sbs_pkg.sv
package sbs_pkg;
	// command codes decoded from cs/ras/cas/we
	typedef enum logic [2:0] {
		SBS_CMD_NOP = 3'h0,
		SBS_CMD_ACT = 3'h1,
		SBS_CMD_RD = 3'h2,
		SBS_CMD_WR = 3'h3,
		SBS_CMD_BST = 3'h4,
		SBS_CMD_PRE = 3'h5,
		SBS_CMD_REF = 3'h6,
		SBS_CMD_MRS = 3'h7
	} sbs_cmd_t;
	// per-bank states
	typedef enum logic [3:0] {
		SBS_IDLE = 4'h0,
		SBS_ACTIVATING = 4'h1,
		SBS_ROW_ACTIVE = 4'h2,
		SBS_READ = 4'h3,
		SBS_WRITE = 4'h4,
		SBS_READ_AP = 4'h5,
		SBS_WRITE_AP = 4'h6,
		SBS_RECOVER_AP = 4'h7,
		SBS_PRECHARGING = 4'h8
	} sbs_bank_state_t;
	// device-wide busy states
	typedef enum logic [2:0] {
		SBS_DEV_NORMAL = 3'h0,
		SBS_DEV_REFRESH = 3'h1,
		SBS_DEV_MODE_LOAD = 3'h2,
		SBS_DEV_PRE_ALL = 3'h3,
		SBS_DEV_SR_EXIT = 3'h4,
		SBS_DEV_SELF_REFRESH = 3'h5
	} sbs_dev_state_t;
	localparam int SBS_BANKS = 4;
	localparam int SBS_BANK_W = 2;
	localparam int SBS_CNT_W = 8;
	localparam int SBS_AUTOCLOSE_BIT = 10;
	localparam int SBS_ADDR_W = 11;
	localparam int SBS_CLK_MHZ = 20;
	// default delays in ns
	localparam int SBS_PRECHARGE_NS = 20;
	localparam int SBS_ROW_TO_COL_NS = 20;
	localparam int SBS_WRITE_RECOVERY_NS = 15;
	localparam int SBS_MODE_LOAD_NS = 15;
	localparam int SBS_REFRESH_NS = 70;
	localparam int SBS_SR_EXIT_NS = 80;
	// least time in cycles, rounded up, at least one
	function automatic logic [7:0] sbs_cycles(input int ns);
		int c;
		c = (ns * SBS_CLK_MHZ + 999) / 1000;
		if (c < 1) begin
			c = 1;
		end
		return c[7:0];
	endfunction
	localparam logic [7:0] SBS_ONE = 8'h01;
	localparam logic [7:0] SBS_ZERO = 8'h00;
	localparam logic [7:0] SBS_LAT_MAX = 8'h03;
	localparam logic [7:0] SBS_BURST_MAX = 8'hff;
endpackage

// file: logic/sbs_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// registers the command pins and decodes one command
module sbs_cmd_decode (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic cke_in,
	output var sbs_pkg::sbs_cmd_t cmd_out,
	output logic cke_prev_out
);
	typedef struct packed {
		sbs_pkg::sbs_cmd_t cmd;
		logic cke_prev;
	} sbs_dec_state_t;
	sbs_dec_state_t st, next_st;
	// encoding of cs ras cas we
	function automatic sbs_pkg::sbs_cmd_t sbs_decode(input logic [3:0] p);
		unique case (p)
			4'h3: return sbs_pkg::SBS_CMD_ACT;
			4'h5: return sbs_pkg::SBS_CMD_RD;
			4'h4: return sbs_pkg::SBS_CMD_WR;
			4'h6: return sbs_pkg::SBS_CMD_BST;
			4'h2: return sbs_pkg::SBS_CMD_PRE;
			4'h1: return sbs_pkg::SBS_CMD_REF;
			4'h0: return sbs_pkg::SBS_CMD_MRS;
			default: return sbs_pkg::SBS_CMD_NOP;
		endcase
	endfunction
	// next decode
	always_comb begin
		next_st.cke_prev = cke_in;
		if (cs_n_in) begin
			next_st.cmd = sbs_pkg::SBS_CMD_NOP;
		end else begin
			next_st.cmd = sbs_decode({1'b0, ras_n_in, cas_n_in, we_n_in});
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			st <= '{cmd: sbs_pkg::SBS_CMD_NOP, cke_prev: 1'b0};
		end else begin
			st <= next_st;
		end
	end
	assign cmd_out = st.cmd;
	assign cke_prev_out = st.cke_prev;
endmodule
`default_nettype wire

// file: logic/sbs_bank_counter.sv
`timescale 1ns/1ps
`default_nettype none
// loadable down counter, done when zero
module sbs_bank_counter #(
	parameter int CNT_W = 8
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic load_in,
	input wire logic [CNT_W-1:0] value_in,
	output logic [CNT_W-1:0] count_out,
	output logic done_out
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
	} sbs_cnt_state_t;
	sbs_cnt_state_t st, next_st;
	// load wins over counting
	always_comb begin
		next_st = st;
		if (load_in) begin
			next_st.count = value_in;
		end else if (st.count != '0) begin
			next_st.count = st.count - 1'b1;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign count_out = st.count;
	assign done_out = (st.count == '0);
endmodule
`default_nettype wire

// file: logic/sbs_bank_tracker.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - commands count only with clock enable high now and before, after exit wait; refresh needs it high only before
// - bank is idle only once precharge period is over
// - row active once row-to-column delay is over and no burst runs
// - read or write state lasts from burst start until it ends or is cut
// - activating starts on activate, becomes row active after row-to-column delay
// - auto-precharge burst keeps bank busy until precharge after burst ends
// - mode load lasts mode-load delay, then all banks idle
// - burst terminate stops the most recent burst in any bank
// - precharge to idle bank changes nothing
// - auto-precharge burst cut by other bank burst starts its own precharge
// - activate or precharge to other bank leaves running burst alone
// - read to other bank cuts plain read one read latency later
// - write to other bank ends plain read at once; mask one clock before
// - write cutting auto-precharge read starts its precharge at once
// - read cutting auto-precharge read starts its precharge at once
// - read to other bank ends a write at registration
// - cut auto-precharge write precharges after write recovery from the cut
module sbs_bank_tracker #(
	parameter int BURST_LEN = 4,
	parameter int READ_LATENCY = 2,
	parameter logic [7:0] PRECHARGE_CYC = sbs_pkg::sbs_cycles(sbs_pkg::SBS_PRECHARGE_NS),
	parameter logic [7:0] ROW_TO_COL_CYC = sbs_pkg::sbs_cycles(sbs_pkg::SBS_ROW_TO_COL_NS),
	parameter logic [7:0] WRITE_RECOVERY_CYC =
		sbs_pkg::sbs_cycles(sbs_pkg::SBS_WRITE_RECOVERY_NS),
	parameter logic [7:0] MODE_LOAD_CYC = sbs_pkg::sbs_cycles(sbs_pkg::SBS_MODE_LOAD_NS),
	parameter logic [7:0] REFRESH_CYC = sbs_pkg::sbs_cycles(sbs_pkg::SBS_REFRESH_NS),
	parameter logic [7:0] SR_EXIT_CYC = sbs_pkg::sbs_cycles(sbs_pkg::SBS_SR_EXIT_NS)
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [sbs_pkg::SBS_BANK_W-1:0] bank_select_bits_in,
	input wire logic autoclose_addr_bit_in,
	output logic [sbs_pkg::SBS_BANKS-1:0] bank_idle_out,
	output logic [sbs_pkg::SBS_BANKS-1:0] bank_row_active_out,
	output logic [sbs_pkg::SBS_BANKS-1:0] bank_bursting_out,
	output logic all_idle_out,
	output logic device_busy_out,
	output logic [sbs_pkg::SBS_BANK_W-1:0] last_burst_bank_out
);
	localparam int NB = sbs_pkg::SBS_BANKS;
	localparam logic [7:0] BURST_CYC = 8'(BURST_LEN);
	localparam logic [7:0] LAT_CYC = 8'(READ_LATENCY);
	typedef struct packed {
		sbs_pkg::sbs_bank_state_t [NB-1:0] bank;
		logic [NB-1:0][7:0] burst_left;
		logic [NB-1:0][7:0] cut_left;
		sbs_pkg::sbs_dev_state_t dev;
		logic [sbs_pkg::SBS_BANK_W-1:0] last_bank;
		logic last_valid;
		logic [NB-1:0] idle_q;
		logic [NB-1:0] active_q;
		logic [NB-1:0] burst_q;
		logic all_idle_q;
		logic busy_q;
	} sbs_trk_state_t;
	sbs_trk_state_t st, next_st;
	sbs_pkg::sbs_cmd_t cmd;
	logic cke_prev;
	logic [sbs_pkg::SBS_BANK_W-1:0] bank_q;
	logic ap_q;
	logic [NB-1:0] cnt_load;
	logic [NB-1:0][7:0] cnt_value;
	logic [NB-1:0] cnt_done;
	logic dev_load;
	logic [7:0] dev_value;
	logic dev_done;
	logic cke_old;
	logic cmd_valid;
	// command decode stage
	sbs_cmd_decode u_dec (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.cs_n_in(cs_n_in),
		.ras_n_in(ras_n_in),
		.cas_n_in(cas_n_in),
		.we_n_in(we_n_in),
		.cke_in(cke_in),
		.cmd_out(cmd),
		.cke_prev_out(cke_prev)
	);
	// address fields and earlier clock enable aligned with decoded command
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			bank_q <= '0;
			ap_q <= 1'b0;
			cke_old <= 1'b0;
		end else begin
			bank_q <= bank_select_bits_in;
			ap_q <= autoclose_addr_bit_in;
			cke_old <= cke_prev;
		end
	end
	genvar g;
	generate
		for (g = 0; g < NB; g++) begin : g_cnt
			sbs_bank_counter #(.CNT_W(sbs_pkg::SBS_CNT_W)) u_cnt (
				.sys_clk_in(sys_clk_in),
				.reset_in(reset_in),
				.load_in(cnt_load[g]),
				.value_in(cnt_value[g]),
				.count_out(),
				.done_out(cnt_done[g])
			);
		end
	endgenerate
	// device-wide interval counter
	sbs_bank_counter #(.CNT_W(sbs_pkg::SBS_CNT_W)) u_dev_cnt (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.load_in(dev_load),
		.value_in(dev_value),
		.count_out(),
		.done_out(dev_done)
	);
	// loads a countdown; one cycle is consumed by the loading edge
	function automatic logic [7:0] sbs_len(input logic [7:0] c);
		return (c > sbs_pkg::SBS_ONE) ? c - sbs_pkg::SBS_ONE : sbs_pkg::SBS_ZERO;
	endfunction
	function automatic logic sbs_is_burst(input sbs_pkg::sbs_bank_state_t s);
		return s inside {sbs_pkg::SBS_READ, sbs_pkg::SBS_WRITE,
			sbs_pkg::SBS_READ_AP, sbs_pkg::SBS_WRITE_AP};
	endfunction
	// command qualified by clock enable and device state
	// clock enable at the edge before the command and at the command edge
	assign cmd_valid = cke_old && cke_prev && (st.dev == sbs_pkg::SBS_DEV_NORMAL);
	// next-state logic
	always_comb begin
		logic is_burst_cmd;
		logic all_idle_n;
		is_burst_cmd = cmd_valid && (cmd == sbs_pkg::SBS_CMD_RD || cmd == sbs_pkg::SBS_CMD_WR);
		all_idle_n = 1'b1;
		next_st = st;
		cnt_load = '0;
		cnt_value = '0;
		dev_load = 1'b0;
		dev_value = '0;
		for (int b = 0; b < NB; b++) begin
			// burst length countdown; the pending cut counts down in the row active, read and write case
			if (next_st.burst_left[b] != sbs_pkg::SBS_ZERO) begin
				next_st.burst_left[b] = next_st.burst_left[b] - sbs_pkg::SBS_ONE;
			end
			unique case (st.bank[b])
				sbs_pkg::SBS_IDLE: begin
					if (cmd_valid && cmd == sbs_pkg::SBS_CMD_ACT && bank_q == b[1:0]) begin
						next_st.bank[b] = sbs_pkg::SBS_ACTIVATING;
						cnt_load[b] = 1'b1;
						cnt_value[b] = sbs_len(ROW_TO_COL_CYC);
					end
				end
				sbs_pkg::SBS_ACTIVATING: begin
					if (cnt_done[b]) begin
						next_st.bank[b] = sbs_pkg::SBS_ROW_ACTIVE;
					end
				end
				sbs_pkg::SBS_ROW_ACTIVE, sbs_pkg::SBS_READ, sbs_pkg::SBS_WRITE: begin
					if (st.bank[b] != sbs_pkg::SBS_ROW_ACTIVE &&
							st.burst_left[b] == sbs_pkg::SBS_ONE) begin
						next_st.bank[b] = sbs_pkg::SBS_ROW_ACTIVE;
					end
					// pending read cut lands after latency
					if (st.cut_left[b] == sbs_pkg::SBS_ONE) begin
						next_st.bank[b] = sbs_pkg::SBS_ROW_ACTIVE;
						next_st.burst_left[b] = sbs_pkg::SBS_ZERO;
					end
					if (st.cut_left[b] != sbs_pkg::SBS_ZERO) begin
						next_st.cut_left[b] = st.cut_left[b] - sbs_pkg::SBS_ONE;
					end
					if (cmd_valid && bank_q == b[1:0] &&
							(cmd == sbs_pkg::SBS_CMD_RD || cmd == sbs_pkg::SBS_CMD_WR)) begin
						if (cmd == sbs_pkg::SBS_CMD_RD) begin
							next_st.bank[b] = ap_q ? sbs_pkg::SBS_READ_AP : sbs_pkg::SBS_READ;
						end else begin
							next_st.bank[b] = ap_q ? sbs_pkg::SBS_WRITE_AP : sbs_pkg::SBS_WRITE;
						end
						next_st.burst_left[b] = BURST_CYC;
						next_st.cut_left[b] = sbs_pkg::SBS_ZERO;
					end else if (is_burst_cmd && bank_q != b[1:0]) begin
						if (st.bank[b] == sbs_pkg::SBS_WRITE ||
								(st.bank[b] == sbs_pkg::SBS_READ &&
								cmd == sbs_pkg::SBS_CMD_WR)) begin
							next_st.bank[b] = sbs_pkg::SBS_ROW_ACTIVE;
							next_st.burst_left[b] = sbs_pkg::SBS_ZERO;
						end else if (st.bank[b] == sbs_pkg::SBS_READ) begin
							next_st.cut_left[b] = LAT_CYC;
						end
					end else if (cmd_valid && cmd == sbs_pkg::SBS_CMD_BST &&
							st.last_valid && st.last_bank == b[1:0] &&
							sbs_is_burst(st.bank[b])) begin
						next_st.bank[b] = sbs_pkg::SBS_ROW_ACTIVE;
						next_st.burst_left[b] = sbs_pkg::SBS_ZERO;
					end else if (cmd_valid && cmd == sbs_pkg::SBS_CMD_PRE &&
							(ap_q || bank_q == b[1:0])) begin
						next_st.bank[b] = sbs_pkg::SBS_PRECHARGING;
						next_st.burst_left[b] = sbs_pkg::SBS_ZERO;
						cnt_load[b] = 1'b1;
						cnt_value[b] = sbs_len(PRECHARGE_CYC);
					end
				end
				sbs_pkg::SBS_READ_AP, sbs_pkg::SBS_WRITE_AP: begin
					if (is_burst_cmd && bank_q != b[1:0]) begin
						next_st.burst_left[b] = sbs_pkg::SBS_ZERO;
						cnt_load[b] = 1'b1;
						if (st.bank[b] == sbs_pkg::SBS_WRITE_AP) begin
							next_st.bank[b] = sbs_pkg::SBS_RECOVER_AP;
							cnt_value[b] = sbs_len(WRITE_RECOVERY_CYC);
						end else begin
							next_st.bank[b] = sbs_pkg::SBS_PRECHARGING;
							cnt_value[b] = sbs_len(PRECHARGE_CYC);
						end
					end else if (st.burst_left[b] == sbs_pkg::SBS_ONE ||
							(cmd_valid && cmd == sbs_pkg::SBS_CMD_BST &&
							st.last_bank == b[1:0])) begin
						next_st.burst_left[b] = sbs_pkg::SBS_ZERO;
						cnt_load[b] = 1'b1;
						if (st.bank[b] == sbs_pkg::SBS_WRITE_AP) begin
							next_st.bank[b] = sbs_pkg::SBS_RECOVER_AP;
							cnt_value[b] = sbs_len(WRITE_RECOVERY_CYC);
						end else begin
							next_st.bank[b] = sbs_pkg::SBS_PRECHARGING;
							cnt_value[b] = sbs_len(PRECHARGE_CYC);
						end
					end
				end
				sbs_pkg::SBS_RECOVER_AP: begin
					// write recovery over, precharge begins
					if (cnt_done[b]) begin
						next_st.bank[b] = sbs_pkg::SBS_PRECHARGING;
						cnt_load[b] = 1'b1;
						cnt_value[b] = sbs_len(PRECHARGE_CYC);
					end
				end
				sbs_pkg::SBS_PRECHARGING: begin
					if (cnt_done[b]) begin
						next_st.bank[b] = sbs_pkg::SBS_IDLE;
					end
				end
				default: begin
					next_st.bank[b] = sbs_pkg::SBS_IDLE;
				end
			endcase
			// precharge to idle bank is a no-op by falling through
		end
		// most recent burst for terminate
		if (is_burst_cmd) begin
			next_st.last_bank = bank_q;
			next_st.last_valid = 1'b1;
		end
		// device-wide states
		for (int b = 0; b < NB; b++) begin
			all_idle_n = all_idle_n && (st.bank[b] == sbs_pkg::SBS_IDLE);
		end
		unique case (st.dev)
			sbs_pkg::SBS_DEV_NORMAL: begin
				if (cke_old && cmd == sbs_pkg::SBS_CMD_REF && all_idle_n) begin
					dev_load = 1'b1;
					// refresh with clock enable low enters self refresh
					if (!cke_prev) begin
						next_st.dev = sbs_pkg::SBS_DEV_SELF_REFRESH;
					end else begin
						next_st.dev = sbs_pkg::SBS_DEV_REFRESH;
						dev_value = sbs_len(REFRESH_CYC);
					end
				end else if (cmd_valid && cmd == sbs_pkg::SBS_CMD_MRS && all_idle_n) begin
					next_st.dev = sbs_pkg::SBS_DEV_MODE_LOAD;
					dev_load = 1'b1;
					dev_value = sbs_len(MODE_LOAD_CYC);
				end else if (cmd_valid && cmd == sbs_pkg::SBS_CMD_PRE && ap_q) begin
					next_st.dev = sbs_pkg::SBS_DEV_PRE_ALL;
					dev_load = 1'b1;
					dev_value = sbs_len(PRECHARGE_CYC);
				end
			end
			sbs_pkg::SBS_DEV_SELF_REFRESH: begin
				if (cke_in) begin
					next_st.dev = sbs_pkg::SBS_DEV_SR_EXIT;
					dev_load = 1'b1;
					dev_value = sbs_len(SR_EXIT_CYC);
				end
			end
			sbs_pkg::SBS_DEV_REFRESH, sbs_pkg::SBS_DEV_MODE_LOAD,
			sbs_pkg::SBS_DEV_PRE_ALL, sbs_pkg::SBS_DEV_SR_EXIT: begin
				if (dev_done) begin
					next_st.dev = sbs_pkg::SBS_DEV_NORMAL;
				end
			end
			default: begin
				next_st.dev = sbs_pkg::SBS_DEV_NORMAL;
			end
		endcase
		// registered status outputs
		for (int b = 0; b < NB; b++) begin
			next_st.idle_q[b] = (next_st.bank[b] == sbs_pkg::SBS_IDLE);
			next_st.active_q[b] = (next_st.bank[b] == sbs_pkg::SBS_ROW_ACTIVE);
			next_st.burst_q[b] = sbs_is_burst(next_st.bank[b]);
		end
		next_st.all_idle_q = &next_st.idle_q;
		next_st.busy_q = (next_st.dev != sbs_pkg::SBS_DEV_NORMAL);
	end
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			st <= '0;
			st.idle_q <= '1;
			st.all_idle_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
	assign bank_idle_out = st.idle_q;
	assign bank_row_active_out = st.active_q;
	assign bank_bursting_out = st.burst_q;
	assign all_idle_out = st.all_idle_q;
	assign device_busy_out = st.busy_q;
	assign last_burst_bank_out = st.last_bank;

	// assertions
	property p_activate_delay;
		@(posedge sys_clk_in) disable iff (reset_in)
		(st.bank[0] == sbs_pkg::SBS_IDLE && cmd_valid && cmd == sbs_pkg::SBS_CMD_ACT &&
			bank_q == 2'h0) |=> st.bank[0] == sbs_pkg::SBS_ACTIVATING;
	endproperty
	a_activate_delay: assert property (p_activate_delay) else $error("activate not taken");
	property p_idle_stays;
		@(posedge sys_clk_in) disable iff (reset_in)
		(st.bank[1] == sbs_pkg::SBS_IDLE && cmd_valid && cmd == sbs_pkg::SBS_CMD_PRE && !ap_q)
			|=> st.bank[1] == sbs_pkg::SBS_IDLE;
	endproperty
	a_idle_stays: assert property (p_idle_stays) else $error("precharge disturbed idle bank");
	property p_no_cmd_without_cke;
		@(posedge sys_clk_in) disable iff (reset_in)
		(!cke_prev && st.bank[0] == sbs_pkg::SBS_IDLE) |=> st.bank[0] != sbs_pkg::SBS_ACTIVATING;
	endproperty
	a_no_cmd_without_cke: assert property (p_no_cmd_without_cke) else $error("command w/o cke");
	property p_pre_to_idle;
		@(posedge sys_clk_in) disable iff (reset_in)
		(st.bank[2] == sbs_pkg::SBS_PRECHARGING && cnt_done[2]) |=> st.bank[2] == sbs_pkg::SBS_IDLE;
	endproperty
	a_pre_to_idle: assert property (p_pre_to_idle) else $error("precharge did not finish");
	property p_row_active;
		@(posedge sys_clk_in) disable iff (reset_in)
		(st.bank[3] == sbs_pkg::SBS_ACTIVATING && cnt_done[3]) |=> st.bank[3] == sbs_pkg::SBS_ROW_ACTIVE;
	endproperty
	a_row_active: assert property (p_row_active) else $error("row active late");
	logic is_burst_cmd_c;
	assign is_burst_cmd_c = cmd_valid && (cmd == sbs_pkg::SBS_CMD_RD || cmd == sbs_pkg::SBS_CMD_WR);
	sequence s_cut_ap_read;
		st.bank[0] == sbs_pkg::SBS_READ_AP && is_burst_cmd_c && bank_q != 2'h0;
	endsequence
	property p_cut_precharge;
		@(posedge sys_clk_in) disable iff (reset_in)
		s_cut_ap_read |=> st.bank[0] == sbs_pkg::SBS_PRECHARGING;
	endproperty
	a_cut_precharge: assert property (p_cut_precharge) else $error("cut read no precharge");
	property p_mode_busy;
		@(posedge sys_clk_in) disable iff (reset_in)
		(st.dev == sbs_pkg::SBS_DEV_NORMAL && cmd_valid && cmd == sbs_pkg::SBS_CMD_MRS &&
			all_idle_out) |=> device_busy_out;
	endproperty
	a_mode_busy: assert property (p_mode_busy) else $error("mode load not busy");
	property p_write_cut_recovery;
		@(posedge sys_clk_in) disable iff (reset_in)
		(st.bank[1] == sbs_pkg::SBS_WRITE_AP && is_burst_cmd_c && bank_q != 2'h1)
			|=> st.bank[1] == sbs_pkg::SBS_RECOVER_AP;
	endproperty
	a_write_cut_recovery: assert property (p_write_cut_recovery) else $error("no recovery");
endmodule
`default_nettype wire

// file: testbench/sbs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side: turns one request into command pins for one edge
module sbs_ctrl_model (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic req_valid_in,
	input wire sbs_pkg::sbs_cmd_t req_cmd_in,
	input wire logic [1:0] req_bank_in,
	input wire logic req_ap_in,
	input wire logic req_cke_in,
	output logic cke_out,
	output logic cs_n_out,
	output logic ras_n_out,
	output logic cas_n_out,
	output logic we_n_out,
	output logic [1:0] bank_out,
	output logic ap_out
);
	// pins change only after an edge; idle bank and autoclose pins toggle so no stale value lingers
	// legal order kept
	always_ff @(posedge sys_clk_in) begin
		cke_out <= reset_in | req_cke_in;
		if (req_valid_in && !reset_in) begin
			bank_out <= req_bank_in;
			ap_out <= req_ap_in;
			case (req_cmd_in)
				sbs_pkg::SBS_CMD_ACT: {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h3;
				sbs_pkg::SBS_CMD_RD: {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h5;
				sbs_pkg::SBS_CMD_WR: {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h4;
				sbs_pkg::SBS_CMD_BST: {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h6;
				sbs_pkg::SBS_CMD_PRE: {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h2;
				// refresh code; clock enable follows the request
				sbs_pkg::SBS_CMD_REF: {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h1;
				sbs_pkg::SBS_CMD_MRS: {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h0;
				default: {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h7;
			endcase
		end else begin
			{cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h7;
			bank_out <= reset_in ? 2'h0 : ~bank_out;
			ap_out <= !reset_in && !ap_out;
		end
	end
endmodule
`default_nettype wire

// file: testbench/sdram_bank_state_rules_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_state_rules_tb;
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic req_valid = 1'b0;
	sbs_pkg::sbs_cmd_t req_cmd = sbs_pkg::SBS_CMD_NOP;
	logic [1:0] req_bank = 2'h0;
	logic req_ap = 1'b0;
	logic req_cke = 1'b1;
	logic cke, cs_n, ras_n, cas_n, we_n, ap;
	logic [1:0] bank, last_bank, b, c;
	logic [3:0] idle, ra, bu, m, n;
	logic all_idle, busy, chk = 1'b0;
	logic [15:0] exp_q[$];
	int miscompares = 0;
	int cmp_count = 0;
	int seed = 32'h875e8827;
	sbs_ctrl_model ctrl (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .req_valid_in(req_valid),
		.req_cmd_in(req_cmd), .req_bank_in(req_bank), .req_ap_in(req_ap), .req_cke_in(req_cke),
		.cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
		.bank_out(bank), .ap_out(ap));
	sbs_bank_tracker #(.BURST_LEN(8), .READ_LATENCY(2)) DUT (.sys_clk_in(sys_clk_in),
		.reset_in(reset_in), .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n),
		.we_n_in(we_n), .bank_select_bits_in(bank), .autoclose_addr_bit_in(ap),
		.bank_idle_out(idle), .bank_row_active_out(ra), .bank_bursting_out(bu),
		.all_idle_out(all_idle), .device_busy_out(busy), .last_burst_bank_out(last_bank));
	// clock
	initial begin
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	// compare one value
	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		cmp_count++;
		if (seen !== expv) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask
	// verdict and end of run
	task automatic stop_test;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one request to the controller model
	task automatic issue(input sbs_pkg::sbs_cmd_t cmd, input logic [1:0] bk, input logic a,
		input logic ck);
		req_valid <= 1'b1;
		req_cmd <= cmd;
		req_bank <= bk;
		req_ap <= a;
		req_cke <= ck;
		@(posedge sys_clk_in);
	endtask
	// idle cycles
	task automatic gap(input int k);
		req_valid <= 1'b0;
		req_cke <= 1'b1;
		repeat (k) @(posedge sys_clk_in);
	endtask
	// note an expected status word for the monitor
	task automatic note(input logic [3:0] i, input logic [3:0] r, input logic [3:0] u,
		input logic ai, input logic bz, input logic [1:0] lb);
		exp_q.push_back({i, r, u, ai, bz, lb});
		chk <= 1'b1;
		@(posedge sys_clk_in);
		chk <= 1'b0;
	endtask
	// monitor takes the oldest note whenever a sample is due
	always @(posedge sys_clk_in) begin
		if (chk) begin
			if (exp_q.size() == 0) begin
				miscompares++;
			end else begin
				check({idle, ra, bu, all_idle, busy, last_bank}, exp_q.pop_front());
			end
		end
	end
	// hang guard
	initial begin
		repeat (5000) @(posedge sys_clk_in);
		miscompares++;
		stop_test;
	end
	// main sequence
	initial begin
		b = 2'($random(seed));
		c = b ^ 2'h1;
		m = 4'h1 << b;
		n = 4'h1 << c;
		repeat (20) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		gap(4);
		note(4'hf, 4'h0, 4'h0, 1'b1, 1'b0, 2'h0);
		issue(sbs_pkg::SBS_CMD_ACT, b, 1'b0, 1'b0);
		gap(6);
		note(4'hf, 4'h0, 4'h0, 1'b1, 1'b0, 2'h0);
		issue(sbs_pkg::SBS_CMD_ACT, b, 1'b0, 1'b1);
		gap(6);
		note(~m, m, 4'h0, 1'b0, 1'b0, 2'h0);
		issue(sbs_pkg::SBS_CMD_PRE, c, 1'b0, 1'b1);
		gap(6);
		note(~m, m, 4'h0, 1'b0, 1'b0, 2'h0);
		issue(sbs_pkg::SBS_CMD_RD, b, 1'b0, 1'b1);
		issue(sbs_pkg::SBS_CMD_BST, b, 1'b0, 1'b1);
		gap(5);
		note(~m, m, 4'h0, 1'b0, 1'b0, b);
		issue(sbs_pkg::SBS_CMD_ACT, c, 1'b0, 1'b1);
		gap(6);
		issue(sbs_pkg::SBS_CMD_RD, c, 1'b1, 1'b1);
		issue(sbs_pkg::SBS_CMD_RD, b, 1'b0, 1'b1);
		gap(5);
		note(~m, 4'h0, m, 1'b0, 1'b0, b);
		gap(20);
		note(~m, m, 4'h0, 1'b0, 1'b0, b);
		issue(sbs_pkg::SBS_CMD_PRE, c, 1'b1, 1'b1);
		gap(8);
		note(4'hf, 4'h0, 4'h0, 1'b1, 1'b0, b);
		issue(sbs_pkg::SBS_CMD_REF, b, 1'b0, 1'b1);
		gap(8);
		note(4'hf, 4'h0, 4'h0, 1'b1, 1'b0, b);
		issue(sbs_pkg::SBS_CMD_MRS, b, 1'b0, 1'b1);
		gap(8);
		note(4'hf, 4'h0, 4'h0, 1'b1, 1'b0, b);
		// refresh with clock enable low, then exit wait
		issue(sbs_pkg::SBS_CMD_REF, b, 1'b0, 1'b0);
		gap(2);
		note(4'hf, 4'h0, 4'h0, 1'b1, 1'b1, b);
		gap(6);
		note(4'hf, 4'h0, 4'h0, 1'b1, 1'b0, b);
		// plain write cut by write, auto-precharge write cut by read
		issue(sbs_pkg::SBS_CMD_ACT, b, 1'b0, 1'b1);
		issue(sbs_pkg::SBS_CMD_ACT, c, 1'b0, 1'b1);
		gap(4);
		issue(sbs_pkg::SBS_CMD_WR, b, 1'b0, 1'b1);
		issue(sbs_pkg::SBS_CMD_WR, c, 1'b1, 1'b1);
		issue(sbs_pkg::SBS_CMD_RD, b, 1'b0, 1'b1);
		gap(5);
		note(~m, 4'h0, m, 1'b0, 1'b0, b);
		gap(3);
		if (exp_q.size() != 0) begin
			miscompares++;
		end
		stop_test;
	end
endmodule
`default_nettype wire
